//--- fp_status_control_regs.sv
// Floating-point status, default status and coprocessor access registers
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module fp_status_control_regs (
    // Clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // Wishbone slave
    input fp_status_control_pkg::fp_status_control_wb_req_t wb_req_i,
    output fp_status_control_pkg::fp_status_control_wb_rsp_t wb_rsp_o,
    // Core privilege state
    input wire logic priv_i,
    // Datapath events
    input fp_status_control_pkg::fp_status_control_flags_t exc_i,
    input wire logic cmp_update_i,
    input wire logic [3:0] cmp_nzcv_i,
    input wire logic ctx_load_default_i,
    // Instruction gate
    input wire logic fp_instr_valid_i,
    output logic fp_instr_accept_o,
    output logic fp_instr_fault_o,
    // Mode controls to datapath
    output fp_status_control_pkg::fp_status_control_mode_t mode_o,
    output fp_status_control_pkg::fp_status_control_round_t round_o,
    output fp_status_control_pkg::fp_status_control_flags_t flags_o,
    output logic [3:0] nzcv_o,
    output logic fpu_enabled_o
);
    import fp_status_control_pkg::*;

    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdat;
        fp_status_control_mode_t mode;
        fp_status_control_mode_t dflt;
        logic [3:0] nzcv;
        logic [3:0] coprocessor_access_control;
    } fp_status_control_regs_state_t;

    fp_status_control_regs_state_t st_r;
    fp_status_control_regs_state_t st_nxt;

    logic take;
    logic sel_stat;
    logic sel_dflt;
    logic sel_coprocessor_access_control;
    logic [31:0] bmask;
    logic [31:0] cur_stat;
    logic [31:0] cur_dflt;
    logic [31:0] cur_coprocessor_access_control;
    logic [31:0] new_stat;
    logic [31:0] new_dflt;
    logic [31:0] new_coprocessor_access_control;
    logic flag_wr;
    logic [FP_STATUS_CONTROL_NFLAGS-1:0] flag_wval;
    logic [FP_STATUS_CONTROL_NFLAGS-1:0] flag_q;
    logic [FP_STATUS_CONTROL_NFLAGS-1:0] flag_set;
    logic [1:0] acc_a;
    logic [1:0] acc_b;
    logic ok_a;
    logic ok_b;

    // Bus decode
    assign take = wb_req_i.cyc && wb_req_i.stb && !st_r.ack && !st_r.err;
    assign sel_stat = (wb_req_i.adr == FP_STATUS_CONTROL_STAT_ADDR);
    assign sel_dflt = (wb_req_i.adr == FP_STATUS_CONTROL_DFLT_ADDR);
    assign sel_coprocessor_access_control = (wb_req_i.adr == FP_STATUS_CONTROL_COPROCESSOR_ACCESS_CONTROL_ADDR);
    assign bmask = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
                    {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};

    // Register images
    always_comb begin
        cur_stat = '0;
        cur_stat[FP_STATUS_CONTROL_POS_NZCV_LO +: 4] = st_r.nzcv;
        cur_stat[FP_STATUS_CONTROL_POS_AHP] = st_r.mode.alt_half_format_sel;
        cur_stat[FP_STATUS_CONTROL_POS_DN] = st_r.mode.default_nan_mode;
        cur_stat[FP_STATUS_CONTROL_POS_FZ] = st_r.mode.flush_zero_mode;
        cur_stat[FP_STATUS_CONTROL_POS_RM_LO +: 2] = st_r.mode.round_select;
        cur_stat[FP_STATUS_CONTROL_POS_IDC] = flag_q[5];
        cur_stat[FP_STATUS_CONTROL_POS_IXC] = flag_q[4];
        cur_stat[FP_STATUS_CONTROL_POS_UFC] = flag_q[3];
        cur_stat[FP_STATUS_CONTROL_POS_OFC] = flag_q[2];
        cur_stat[FP_STATUS_CONTROL_POS_DZC] = flag_q[1];
        cur_stat[FP_STATUS_CONTROL_POS_IOC] = flag_q[0];
        cur_dflt = '0;
        cur_dflt[FP_STATUS_CONTROL_POS_AHP] = st_r.dflt.alt_half_format_sel;
        cur_dflt[FP_STATUS_CONTROL_POS_DN] = st_r.dflt.default_nan_mode;
        cur_dflt[FP_STATUS_CONTROL_POS_FZ] = st_r.dflt.flush_zero_mode;
        cur_dflt[FP_STATUS_CONTROL_POS_RM_LO +: 2] = st_r.dflt.round_select;
        cur_coprocessor_access_control = '0;
        cur_coprocessor_access_control[FP_STATUS_CONTROL_POS_CPA_LO +: 4] = st_r.coprocessor_access_control;
    end

    // Byte-lane merge, reserved bits forced to zero
    assign new_stat = ((cur_stat & ~bmask) | (wb_req_i.dat & bmask)) & FP_STATUS_CONTROL_STAT_MASK;
    assign new_dflt = ((cur_dflt & ~bmask) | (wb_req_i.dat & bmask)) & FP_STATUS_CONTROL_DFLT_MASK;
    assign new_coprocessor_access_control = (cur_coprocessor_access_control & ~bmask) | (wb_req_i.dat & bmask);

    // Flag write path
    assign flag_wr = ce_i && take && wb_req_i.we && sel_stat;
    assign flag_wval = {new_stat[FP_STATUS_CONTROL_POS_IDC], new_stat[FP_STATUS_CONTROL_POS_IXC],
                        new_stat[FP_STATUS_CONTROL_POS_UFC], new_stat[FP_STATUS_CONTROL_POS_OFC],
                        new_stat[FP_STATUS_CONTROL_POS_DZC], new_stat[FP_STATUS_CONTROL_POS_IOC]};
    assign flag_set = exc_i;

    genvar gi;
    generate
        for (gi = 0; gi < FP_STATUS_CONTROL_NFLAGS; gi++) begin : g_flag
            fp_status_control_sticky_bit u_flag (
                .clk_sys_i(clk_sys_i),
                .nrst_i(nrst_i),
                .ce_i(ce_i),
                .set_i(flag_set[gi]),
                .wr_i(flag_wr),
                .wr_val_i(flag_wval[gi]),
                .flag_o(flag_q[gi])
            );
        end
    endgenerate

    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        st_nxt.err = 1'b0;
        if (take) begin
            st_nxt.rdat = '0;
            if (sel_coprocessor_access_control && !priv_i) begin
                st_nxt.err = 1'b1;
            end else begin
                st_nxt.ack = 1'b1;
                if (wb_req_i.we) begin
                    if (sel_stat) begin
                        st_nxt.nzcv = new_stat[FP_STATUS_CONTROL_POS_NZCV_LO +: 4];
                        st_nxt.mode.alt_half_format_sel = new_stat[FP_STATUS_CONTROL_POS_AHP];
                        st_nxt.mode.default_nan_mode = new_stat[FP_STATUS_CONTROL_POS_DN];
                        st_nxt.mode.flush_zero_mode = new_stat[FP_STATUS_CONTROL_POS_FZ];
                        st_nxt.mode.round_select = new_stat[FP_STATUS_CONTROL_POS_RM_LO +: 2];
                    end
                    if (sel_dflt) begin
                        st_nxt.dflt.alt_half_format_sel = new_dflt[FP_STATUS_CONTROL_POS_AHP];
                        st_nxt.dflt.default_nan_mode = new_dflt[FP_STATUS_CONTROL_POS_DN];
                        st_nxt.dflt.flush_zero_mode = new_dflt[FP_STATUS_CONTROL_POS_FZ];
                        st_nxt.dflt.round_select = new_dflt[FP_STATUS_CONTROL_POS_RM_LO +: 2];
                    end
                    if (sel_coprocessor_access_control) begin
                        st_nxt.coprocessor_access_control = new_coprocessor_access_control[FP_STATUS_CONTROL_POS_CPA_LO +: 4];
                    end
                end else begin
                    if (sel_stat) begin
                        st_nxt.rdat = cur_stat;
                    end else if (sel_dflt) begin
                        st_nxt.rdat = cur_dflt;
                    end else if (sel_coprocessor_access_control) begin
                        st_nxt.rdat = cur_coprocessor_access_control;
                    end
                end
            end
        end
        // Context entry loads defaults into the mode fields
        if (ctx_load_default_i) begin
            st_nxt.mode = st_r.dflt;
        end
        // Comparison results win over a bus write in the same cycle
        if (cmp_update_i) begin
            st_nxt.nzcv = cmp_nzcv_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            st_r.ack <= 1'b0;
            st_r.err <= 1'b0;
            st_r.rdat <= '0;
            st_r.mode <= FP_STATUS_CONTROL_MODE_RST;
            st_r.dflt <= FP_STATUS_CONTROL_MODE_RST;
            st_r.nzcv <= FP_STATUS_CONTROL_NZCV_RST;
            st_r.coprocessor_access_control <= FP_STATUS_CONTROL_COPROCESSOR_ACCESS_CONTROL_RST;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    // Access grant per coprocessor field
    assign acc_a = st_r.coprocessor_access_control[1:0];
    assign acc_b = st_r.coprocessor_access_control[3:2];
    assign ok_a = (acc_a == FP_STATUS_CONTROL_ACC_FULL) || ((acc_a == FP_STATUS_CONTROL_ACC_PRIV) && priv_i);
    assign ok_b = (acc_b == FP_STATUS_CONTROL_ACC_FULL) || ((acc_b == FP_STATUS_CONTROL_ACC_PRIV) && priv_i);
    assign fpu_enabled_o = ok_a && ok_b;
    assign fp_instr_accept_o = fp_instr_valid_i && fpu_enabled_o;
    assign fp_instr_fault_o = fp_instr_valid_i && !fpu_enabled_o;

    // Datapath controls
    assign mode_o = st_r.mode;
    assign flags_o = flag_q;
    assign nzcv_o = st_r.nzcv;
    assign wb_rsp_o.ack = st_r.ack;
    assign wb_rsp_o.err = st_r.err;
    assign wb_rsp_o.dat = st_r.rdat;

    fp_status_control_round_decode u_round (
        .round_select_i(st_r.mode.round_select),
        .round_o(round_o)
    );

    // Checks
    sequence s_coprocessor_access_control_grant;
        ce_i && take && wb_req_i.we && sel_coprocessor_access_control && priv_i && (wb_req_i.sel[2] == 1'b1)
            && (wb_req_i.dat[FP_STATUS_CONTROL_POS_CPA_LO +: 4] == 4'hF);
    endsequence

    sequence s_stat_read;
        ce_i && take && !wb_req_i.we && sel_stat;
    endsequence

    AST_ACK_DROPS: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (wb_rsp_o.ack && ce_i) |=> !wb_rsp_o.ack)
        else $error("ack held for more than one cycle");

    AST_PRIV_BLOCK: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (ce_i && take && sel_coprocessor_access_control && !priv_i) |=> (wb_rsp_o.err && $stable(st_r.coprocessor_access_control)))
        else $error("unprivileged access control access not refused");

    AST_ENABLE_SEQ: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_coprocessor_access_control_grant |=> (st_r.coprocessor_access_control == 4'hF) ##0 fpu_enabled_o)
        else $error("granting both coprocessors did not enable the unit");

    AST_RESET_OFF: assert property (@(posedge clk_sys_i)
        !nrst_i |=> (!fpu_enabled_o && !fp_instr_accept_o))
        else $error("unit enabled right after reset");

    AST_NO_EXEC: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (fp_instr_valid_i && (st_r.coprocessor_access_control == 4'h0)) |-> (fp_instr_fault_o && !fp_instr_accept_o))
        else $error("instruction accepted while unit disabled");

    AST_FLAG_SET: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (ce_i && exc_i.invalid_op_flag) |=> flags_o.invalid_op_flag)
        else $error("invalid operation event not recorded");

    AST_FLAG_HOLD: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (ce_i && flags_o.input_denormal_flag && !flag_wr) |=> flags_o.input_denormal_flag)
        else $error("denormal flag cleared without a write");

    AST_RESERVED_ZERO: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_stat_read |=> (wb_rsp_o.ack && (wb_rsp_o.dat[27] == 1'b0)
            && (wb_rsp_o.dat[21:8] == 14'h0) && (wb_rsp_o.dat[6:5] == 2'h0)))
        else $error("reserved status bits read nonzero");

    AST_FLAG_POS: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_stat_read |=> (wb_rsp_o.dat[7] == $past(flag_q[5]))
            && (wb_rsp_o.dat[0] == $past(flag_q[0])))
        else $error("flag placed at wrong bit position");

    AST_CMP_NZCV: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (ce_i && cmp_update_i) |=> (nzcv_o == $past(cmp_nzcv_i)))
        else $error("comparison flags not updated");

    AST_DFLT_LOAD: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (ce_i && ctx_load_default_i) |=> (mode_o == $past(st_r.dflt)))
        else $error("default mode not loaded on context entry");

    AST_ROUND_ZERO: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (mode_o.round_select == 2'h3) |-> (round_o.to_zero && !round_o.nearest))
        else $error("toward-zero rounding not decoded");
endmodule

//--- fp_status_control_pkg.sv
// Shared constants and types for the floating-point status and control registers
package fp_status_control_pkg;

    // Byte addresses of the registers
    localparam logic [31:0] FP_STATUS_CONTROL_COPROCESSOR_ACCESS_CONTROL_ADDR = 32'hE000ED88;
    localparam logic [31:0] FP_STATUS_CONTROL_STAT_ADDR = 32'hE000EE00;
    localparam logic [31:0] FP_STATUS_CONTROL_DFLT_ADDR = 32'hE000EE04;

    // Field positions in the status control word
    localparam int FP_STATUS_CONTROL_POS_NZCV_LO = 28;
    localparam int FP_STATUS_CONTROL_POS_AHP = 26;
    localparam int FP_STATUS_CONTROL_POS_DN = 25;
    localparam int FP_STATUS_CONTROL_POS_FZ = 24;
    localparam int FP_STATUS_CONTROL_POS_RM_LO = 22;
    localparam int FP_STATUS_CONTROL_POS_IDC = 7;
    localparam int FP_STATUS_CONTROL_POS_IXC = 4;
    localparam int FP_STATUS_CONTROL_POS_UFC = 3;
    localparam int FP_STATUS_CONTROL_POS_OFC = 2;
    localparam int FP_STATUS_CONTROL_POS_DZC = 1;
    localparam int FP_STATUS_CONTROL_POS_IOC = 0;

    // Field positions in the access control word
    localparam int FP_STATUS_CONTROL_POS_CPA_LO = 20;
    localparam int FP_STATUS_CONTROL_POS_CPB_LO = 22;

    // Access field codes
    localparam logic [1:0] FP_STATUS_CONTROL_ACC_DENY = 2'h0;
    localparam logic [1:0] FP_STATUS_CONTROL_ACC_PRIV = 2'h1;
    localparam logic [1:0] FP_STATUS_CONTROL_ACC_FULL = 2'h3;

    // Rounding codes
    localparam logic [1:0] FP_STATUS_CONTROL_RM_NEAREST = 2'h0;
    localparam logic [1:0] FP_STATUS_CONTROL_RM_PLUS = 2'h1;
    localparam logic [1:0] FP_STATUS_CONTROL_RM_MINUS = 2'h2;
    localparam logic [1:0] FP_STATUS_CONTROL_RM_ZERO = 2'h3;

    // Writable bits and values after reset
    localparam logic [31:0] FP_STATUS_CONTROL_STAT_MASK = 32'hF7C0009F;
    localparam logic [31:0] FP_STATUS_CONTROL_DFLT_MASK = 32'h07C00000;
    localparam logic [3:0] FP_STATUS_CONTROL_COPROCESSOR_ACCESS_CONTROL_RST = 4'h0;
    localparam logic [3:0] FP_STATUS_CONTROL_NZCV_RST = 4'h0;
    localparam int FP_STATUS_CONTROL_NFLAGS = 6;

    typedef struct packed {
        logic alt_half_format_sel;
        logic default_nan_mode;
        logic flush_zero_mode;
        logic [1:0] round_select;
    } fp_status_control_mode_t;

    localparam fp_status_control_mode_t FP_STATUS_CONTROL_MODE_RST = 5'h00;

    typedef struct packed {
        logic input_denormal_flag;
        logic inexact_flag;
        logic underflow_flag;
        logic overflow_flag;
        logic div_zero_flag;
        logic invalid_op_flag;
    } fp_status_control_flags_t;

    typedef struct packed {
        logic nearest;
        logic plus_inf;
        logic minus_inf;
        logic to_zero;
    } fp_status_control_round_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [31:0] adr;
        logic [31:0] dat;
    } fp_status_control_wb_req_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] dat;
    } fp_status_control_wb_rsp_t;

endpackage

//--- fp_status_control_sticky_bit.sv
// One cumulative exception flag, set by hardware, cleared by a write or by reset
`timescale 1ns/1ps
module fp_status_control_sticky_bit (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // Event and write
    input wire logic set_i,
    input wire logic wr_i,
    input wire logic wr_val_i,
    // Flag
    output logic flag_o
);
    import fp_status_control_pkg::*;

    typedef struct packed {
        logic flag;
    } fp_status_control_sticky_t;

    fp_status_control_sticky_t st_r;
    fp_status_control_sticky_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (wr_i) begin
            st_nxt.flag = wr_val_i;
        end
        if (set_i) begin
            st_nxt.flag = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            st_r <= '0;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    assign flag_o = st_r.flag;
endmodule

//--- fp_status_control_round_decode.sv
// Decodes the rounding field into one-hot rounding controls
`timescale 1ns/1ps
module fp_status_control_round_decode (
    // Rounding field
    input wire logic [1:0] round_select_i,
    // One-hot rounding controls
    output fp_status_control_pkg::fp_status_control_round_t round_o
);
    import fp_status_control_pkg::*;

    always_comb begin
        round_o = '0;
        case (round_select_i)
            FP_STATUS_CONTROL_RM_NEAREST: begin
                round_o.nearest = 1'b1;
            end
            FP_STATUS_CONTROL_RM_PLUS: begin
                round_o.plus_inf = 1'b1;
            end
            FP_STATUS_CONTROL_RM_MINUS: begin
                round_o.minus_inf = 1'b1;
            end
            FP_STATUS_CONTROL_RM_ZERO: begin
                round_o.to_zero = 1'b1;
            end
            default: begin
                round_o.nearest = 1'b1;
            end
        endcase
    end
endmodule

//--- fp_status_control_core_model.sv
// Behavioural processor core that drives datapath events and instruction issue
`timescale 1ns/1ps
module fp_status_control_core_model (
    // Clock
    input wire logic clk_sys_i,
    // Instruction gate
    input wire logic accept_i,
    input wire logic fault_i,
    // Events to the registers
    output logic priv_o,
    output fp_status_control_pkg::fp_status_control_flags_t exc_o,
    output logic cmp_update_o,
    output logic [3:0] cmp_nzcv_o,
    output logic ctx_load_o,
    output logic valid_o
);
    import fp_status_control_pkg::*;

    initial begin
        priv_o = 1'h1;
        exc_o = '0;
        cmp_update_o = 1'h0;
        cmp_nzcv_o = 4'h0;
        ctx_load_o = 1'h0;
        valid_o = 1'h0;
    end

    // Privilege level of running code
    task automatic set_priv(input logic p);
        @(posedge clk_sys_i);
        priv_o <= p;
    endtask

    // One-cycle exception event pulse
    task automatic raise(input logic [5:0] f);
        @(posedge clk_sys_i);
        exc_o <= f;
        @(posedge clk_sys_i);
        exc_o <= '0;
    endtask

    // Comparison result pulse
    task automatic compare(input logic [3:0] v);
        @(posedge clk_sys_i);
        cmp_update_o <= 1'h1;
        cmp_nzcv_o <= v;
        @(posedge clk_sys_i);
        cmp_update_o <= 1'h0;
    endtask

    // Load default mode fields
    task automatic load_default;
        @(posedge clk_sys_i);
        ctx_load_o <= 1'h1;
        @(posedge clk_sys_i);
        ctx_load_o <= 1'h0;
    endtask

    // Store completion and pipeline flush after enabling
    task automatic settle;
        repeat (2) @(posedge clk_sys_i);
    endtask

    // Try to issue one instruction
    task automatic issue(output logic a, output logic f);
        @(posedge clk_sys_i);
        valid_o <= 1'h1;
        @(posedge clk_sys_i);
        a = accept_i;
        f = fault_i;
        valid_o <= 1'h0;
    endtask
endmodule

//--- fp_status_control_regs_test.sv
// Self-checking bench for the floating-point status and control registers
`timescale 1ns/1ps
module fp_status_control_regs_test;
    import fp_status_control_pkg::*;
    logic clk_sys_i = 1'h0;
    logic nrst_i = 1'h0;
    logic ce_i = 1'h1;
    fp_status_control_wb_req_t req = '0;
    fp_status_control_wb_rsp_t rsp;
    logic priv, cmp_up, ctx_ld, valid, accept, fault, enabled, a, f, er;
    fp_status_control_flags_t exc, flags;
    logic [3:0] cmp_v, nzcv;
    fp_status_control_mode_t mode;
    fp_status_control_round_t round;
    int fail_count = 0;
    int checked = 0;
    logic [31:0] lfsr = 32'h00010EB8;
    logic [31:0] rd, w;
    logic [5:0] acc;

    always #2.5 clk_sys_i = ~clk_sys_i;

    fp_status_control_regs u_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce_i),
        .wb_req_i(req), .wb_rsp_o(rsp), .priv_i(priv), .exc_i(exc),
        .cmp_update_i(cmp_up), .cmp_nzcv_i(cmp_v), .ctx_load_default_i(ctx_ld),
        .fp_instr_valid_i(valid), .fp_instr_accept_o(accept),
        .fp_instr_fault_o(fault), .mode_o(mode), .round_o(round),
        .flags_o(flags), .nzcv_o(nzcv), .fpu_enabled_o(enabled));

    fp_status_control_core_model u_core (.clk_sys_i(clk_sys_i), .accept_i(accept),
        .fault_i(fault), .priv_o(priv), .exc_o(exc), .cmp_update_o(cmp_up),
        .cmp_nzcv_o(cmp_v), .ctx_load_o(ctx_ld), .valid_o(valid));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], 1'h0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
    endfunction

    function automatic logic [4:0] mode_of(input logic [31:0] v);
        return {v[26], v[25], v[24], v[23:22]};
    endfunction

    task automatic check(input string name, input logic [32:0] seen,
                         input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Classic single Wishbone cycle
    task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] dat,
                      output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        req <= '{cyc: 1'h1, stb: 1'h1, we: we, sel: 4'hF, adr: adr, dat: dat};
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (rsp.ack !== 1'h1 && rsp.err !== 1'h1 && n < 50);
        if (n >= 50) begin
            fail_count++;
            tally_and_finish();
        end
        r = rsp.dat;
        e = rsp.err;
        req <= '0;
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        fail_count++;
        tally_and_finish();
    end

    initial begin
        repeat (2) @(posedge clk_sys_i);
        nrst_i <= 1'h1;
        wb(1'h0, FP_STATUS_CONTROL_STAT_ADDR, 32'h0, rd, er);
        check("stat reset", rd, 32'h0);
        wb(1'h0, FP_STATUS_CONTROL_DFLT_ADDR, 32'h0, rd, er);
        check("default reset", rd, 32'h0);
        u_core.issue(a, f);
        check("gate at reset", {a, f, enabled}, 32'h2);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            w = {lfsr[31:24], i[1:0], lfsr[21:0]};
            wb(1'h1, FP_STATUS_CONTROL_STAT_ADDR, w, rd, er);
            wb(1'h0, FP_STATUS_CONTROL_STAT_ADDR, 32'h0, rd, er);
            check("stat readback", rd, w & FP_STATUS_CONTROL_STAT_MASK);
            check("mode", mode, mode_of(w));
            check("round", round, 4'h8 >> i);
            check("flags", flags, {w[7], w[4:0]});
            check("nzcv", nzcv, w[31:28]);
        end
        $display("test modes done");
        for (int i = 0; i < 2; i++) begin
            lfsr = lfsr_next(lfsr);
            w = lfsr ^ {5'h00, i[0], 26'h0};
            wb(1'h1, FP_STATUS_CONTROL_DFLT_ADDR, w, rd, er);
            wb(1'h0, FP_STATUS_CONTROL_DFLT_ADDR, 32'h0, rd, er);
            check("default readback", rd, w & FP_STATUS_CONTROL_DFLT_MASK);
            wb(1'h1, FP_STATUS_CONTROL_STAT_ADDR, 32'h0, rd, er);
            u_core.load_default();
            @(posedge clk_sys_i);
            check("mode from default", mode, mode_of(w));
        end
        $display("test defaults done");
        acc = 6'h00;
        for (int b = 0; b < 6; b++) begin
            u_core.raise(6'h01 << b);
            acc = acc | (6'h01 << b);
            repeat (3) @(posedge clk_sys_i);
            check("flags accumulate", flags, acc);
        end
        wb(1'h0, FP_STATUS_CONTROL_STAT_ADDR, 32'h0, rd, er);
        check("flag positions", rd & 32'hFF, 32'h9F);
        wb(1'h1, FP_STATUS_CONTROL_STAT_ADDR, 32'h0, rd, er);
        check("flags cleared", flags, 6'h00);
        lfsr = lfsr_next(lfsr);
        u_core.raise(lfsr[5:0]);
        u_core.compare(lfsr[9:6]);
        wb(1'h0, FP_STATUS_CONTROL_STAT_ADDR, 32'h0, rd, er);
        check("random flags", {rd[7], rd[4:0]}, lfsr[5:0]);
        check("compare flags", rd[31:28], lfsr[9:6]);
        $display("test flags done");
        u_core.set_priv(1'h0);
        wb(1'h1, FP_STATUS_CONTROL_COPROCESSOR_ACCESS_CONTROL_ADDR, 32'h00F00000, rd, er);
        check("user write refused", er, 1'h1);
        wb(1'h0, FP_STATUS_CONTROL_COPROCESSOR_ACCESS_CONTROL_ADDR, 32'h0, rd, er);
        check("user read refused", {er, rd}, {1'h1, 32'h0});
        u_core.set_priv(1'h1);
        wb(1'h0, FP_STATUS_CONTROL_COPROCESSOR_ACCESS_CONTROL_ADDR, 32'h0, rd, er);
        check("access before enable", {er, rd}, 33'h0);
        wb(1'h1, FP_STATUS_CONTROL_COPROCESSOR_ACCESS_CONTROL_ADDR, rd | (32'hF << 20), rd, er);
        check("enable write", er, 1'h0);
        u_core.settle();
        wb(1'h0, FP_STATUS_CONTROL_COPROCESSOR_ACCESS_CONTROL_ADDR, 32'h0, rd, er);
        check("access enabled", rd, 32'h00F00000);
        u_core.issue(a, f);
        check("gate enabled", {a, f, enabled}, 32'h5);
        $display("test access done");
        wb(1'h1, 32'hE000EE08, lfsr, rd, er);
        wb(1'h0, 32'hE000EE08, 32'h0, rd, er);
        check("unmapped", {er, rd}, 33'h0);
        $display("test unmapped done");
        wb(1'h1, FP_STATUS_CONTROL_STAT_ADDR, 32'h0, rd, er);
        @(posedge clk_sys_i);
        ce_i <= 1'h0;
        u_core.raise(6'h01);
        u_core.compare(4'hA);
        @(posedge clk_sys_i);
        check("frozen flags", flags, 6'h00);
        check("frozen nzcv", nzcv, 4'h0);
        ce_i <= 1'h1;
        u_core.raise(6'h01);
        @(posedge clk_sys_i);
        check("flag after enable", flags, 6'h01);
        $display("test clock enable done");
        tally_and_finish();
    end
endmodule
